// File: hdl/ttu_classic_timer.v
// Classic 13/16/8-bit reload/split timer core
`timescale 1ns/100ps
`include "ttu_defs.vh"
module ttu_classic_timer #(
  parameter SPLIT = 1
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rstn,
  input wire ce,
  // Count events and mode
  input wire step,
  input wire hi_step,
  input wire [1:0] mode,
  // Software access
  input wire wr_lo,
  input wire wr_hi,
  input wire [7:0] wdata,
  // Count and overflow
  output reg [7:0] cnt_lo,
  output reg [7:0] cnt_hi,
  output wire ovf,
  output wire hi_ovf
);
  wire [12:0] c13;
  wire [15:0] c16;
  wire split_on;

  assign c13 = {cnt_hi, cnt_lo[4:0]};
  assign c16 = {cnt_hi, cnt_lo};
  assign split_on = (SPLIT != 0) && (mode == `TTU_MODE_SPLIT);

  // Overflow of the active counter per mode
  assign ovf = step & (((mode == `TTU_MODE_13BIT) && (c13 == 13'h1FFF)) ||
    ((mode == `TTU_MODE_16BIT) && (c16 == 16'hFFFF)) ||
    (((mode == `TTU_MODE_AUTO8) || split_on) && (cnt_lo == 8'hFF)));
  assign hi_ovf = split_on & hi_step & (cnt_hi == 8'hFF);

  // Software writes win over counting in the same cycle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
    end else if (ce) begin
      if (wr_lo) begin
        cnt_lo <= wdata;
      end else if (step) begin
        case (mode)
          `TTU_MODE_13BIT: cnt_lo <= {cnt_lo[7:5], c13[4:0] + 5'h01};
          `TTU_MODE_16BIT: cnt_lo <= cnt_lo + 8'h01;
          `TTU_MODE_AUTO8: cnt_lo <= ovf ? cnt_hi : cnt_lo + 8'h01;
          default: cnt_lo <= split_on ? cnt_lo + 8'h01 : cnt_lo;
        endcase
      end
      if (wr_hi) begin
        cnt_hi <= wdata;
      end else if (split_on) begin
        if (hi_step) begin
          cnt_hi <= cnt_hi + 8'h01;
        end
      end else if (step) begin
        case (mode)
          `TTU_MODE_13BIT: begin
            if (c13[4:0] == 5'h1F) begin
              cnt_hi <= cnt_hi + 8'h01;
            end
          end
          `TTU_MODE_16BIT: begin
            if (cnt_lo == 8'hFF) begin
              cnt_hi <= cnt_hi + 8'h01;
            end
          end
          default: cnt_hi <= cnt_hi; // Reload value or held
        endcase
      end
    end
  end
endmodule // ttu_classic_timer

// File: hdl/ttu_defs.vh
// Register addresses, field positions, reset values and counts
`ifndef TTU_DEFS_VH
`define TTU_DEFS_VH

// Register addresses
`define TTU_ADDR_AUX 8'h8E
`define TTU_ADDR_AUX2 8'hA6
`define TTU_ADDR_T3CTL 8'hC8
`define TTU_ADDR_T3MOD 8'hC9
`define TTU_ADDR_CAP_LO 8'hCA
`define TTU_ADDR_CAP_HI 8'hCB
`define TTU_ADDR_T3_LO 8'hCC
`define TTU_ADDR_T3_HI 8'hCD
`define TTU_ADDR_CLCTL 8'hD8
`define TTU_ADDR_CLMODE 8'hD9
`define TTU_ADDR_T1_LO 8'hDA
`define TTU_ADDR_T1_HI 8'hDB
`define TTU_ADDR_T2_LO 8'hDC
`define TTU_ADDR_T2_HI 8'hDD

// aux_control fields
`define TTU_AUX_PTR_SEL 0
`define TTU_AUX_T3_FAST 3
`define TTU_AUX_BAUD_ADJ 5
`define TTU_AUX_MASK 8'h29

// aux_control_two fields
`define TTU_AUX2_T1_CKOE 0
`define TTU_AUX2_SER0 5
`define TTU_AUX2_T2_FAST 6
`define TTU_AUX2_T1_FAST 7
`define TTU_AUX2_MASK 8'hE1

// timer_three_control fields
`define TTU_T3C_CPRL 0
`define TTU_T3C_CT 1
`define TTU_T3C_RUN 2
`define TTU_T3C_EXEN 3
`define TTU_T3C_TRANSMIT_CLOCK_SELECTOR 4
`define TTU_T3C_RCLK 5
`define TTU_T3C_EXF 6
`define TTU_T3C_TF 7

// timer_three_mode fields
`define TTU_T3M_DOWN_COUNT_ENABLE 0
`define TTU_T3M_OE 1
`define TTU_T3M_MASK 8'h03

// classic_control fields
`define TTU_CLC_RUN1 0
`define TTU_CLC_RUN2 1
`define TTU_CLC_TF1 4
`define TTU_CLC_TF2 5
`define TTU_CLC_MASK 8'h33

// classic_mode fields: mode in [1:0]/[5:4], counter select in 2/6
`define TTU_CLM_MODE1_LSB 0
`define TTU_CLM_CT1 2
`define TTU_CLM_MODE2_LSB 4
`define TTU_CLM_CT2 6
`define TTU_CLM_MASK 8'h77

// Reset value of every register
`define TTU_RESET_BYTE 8'h00

// Slow time base divides the system clock by this count
`define TTU_PRESCALE 12
`define TTU_PRESCALE_W 4

// Classic timer modes
`define TTU_MODE_13BIT 2'h0
`define TTU_MODE_16BIT 2'h1
`define TTU_MODE_AUTO8 2'h2
`define TTU_MODE_SPLIT 2'h3

`endif

// File: hdl/ttu_edge_sync.v
// Two-stage pin synchroniser with falling edge detector
`timescale 1ns/100ps
module ttu_edge_sync (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rstn,
  input wire ce,
  // Raw pin
  input wire pin,
  // Synchronised level and falling edge pulse
  output wire level,
  output wire fall
);
  reg meta;
  reg sync;
  reg last;

  // Only sync and last feed logic; meta is left alone to settle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else if (ce) begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign fall = last & ~sync & ce;
endmodule // ttu_edge_sync

// File: hdl/ttu_top.v
// Three-timer unit: two classic timers and the capture/reload timer
`timescale 1ns/100ps
`include "ttu_defs.vh"
module ttu_top (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rstn,
  input wire ce,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // External pins
  input wire trigger_pin,
  input wire external_count_pin,
  input wire first_count_pin,
  input wire second_count_pin,
  // Clock outputs
  output reg first_clock_out,
  output wire first_clock_out_oe,
  output reg third_clock_out,
  output wire third_clock_out_oe,
  // Serial port clocks
  output wire rx_baud_tick,
  output wire tx_baud_tick,
  // Loose control bits for neighbouring blocks
  output wire pointer_select,
  output wire baud_adjust_bit,
  output wire serial_mode0_speed_sel,
  // Interrupt requests
  output wire first_timer_irq,
  output wire second_timer_irq,
  output wire third_timer_irq
);
  // Register state
  reg [7:0] aux_control;
  reg [7:0] aux_control_two;
  reg [7:0] timer_three_mode;
  reg [7:0] classic_control;
  reg [7:0] classic_mode;
  reg capture_reload_select;
  reg timer_counter_select;
  reg third_timer_run;
  reg external_trigger_enable;
  reg transmit_clock_selector;
  reg receive_clock_selector;
  reg external_trigger_flag;
  reg third_timer_overflow_flag;
  reg [7:0] capture_reload_low;
  reg [7:0] capture_reload_high;
  reg [7:0] t3_lo;
  reg [7:0] t3_hi;
  reg [`TTU_PRESCALE_W-1:0] prescale;
  reg half_tick;
  reg [15:0] next_count;
  reg next_exf;
  // Register write strobe for one address
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input wr;
    begin
      wr_hit = wr & (addr == target);
    end
  endfunction
  // Decoded writes
  wire wr_aux = wr_hit(sfr_addr, `TTU_ADDR_AUX, sfr_wr);
  wire wr_aux2 = wr_hit(sfr_addr, `TTU_ADDR_AUX2, sfr_wr);
  wire wr_t3c = wr_hit(sfr_addr, `TTU_ADDR_T3CTL, sfr_wr);
  wire wr_t3m = wr_hit(sfr_addr, `TTU_ADDR_T3MOD, sfr_wr);
  wire wr_cap_lo = wr_hit(sfr_addr, `TTU_ADDR_CAP_LO, sfr_wr);
  wire wr_cap_hi = wr_hit(sfr_addr, `TTU_ADDR_CAP_HI, sfr_wr);
  wire wr_t3_lo = wr_hit(sfr_addr, `TTU_ADDR_T3_LO, sfr_wr);
  wire wr_t3_hi = wr_hit(sfr_addr, `TTU_ADDR_T3_HI, sfr_wr);
  wire wr_clc = wr_hit(sfr_addr, `TTU_ADDR_CLCTL, sfr_wr);
  wire wr_clm = wr_hit(sfr_addr, `TTU_ADDR_CLMODE, sfr_wr);
  wire wr_t1_lo = wr_hit(sfr_addr, `TTU_ADDR_T1_LO, sfr_wr);
  wire wr_t1_hi = wr_hit(sfr_addr, `TTU_ADDR_T1_HI, sfr_wr);
  wire wr_t2_lo = wr_hit(sfr_addr, `TTU_ADDR_T2_LO, sfr_wr);
  wire wr_t2_hi = wr_hit(sfr_addr, `TTU_ADDR_T2_HI, sfr_wr);
  // Field aliases
  wire first_timer_fast_clock_sel = aux_control_two[`TTU_AUX2_T1_FAST];
  wire second_timer_fast_clock_sel = aux_control_two[`TTU_AUX2_T2_FAST];
  wire first_timer_clock_out_en = aux_control_two[`TTU_AUX2_T1_CKOE];
  wire third_timer_fast_clock_sel = aux_control[`TTU_AUX_T3_FAST];
  wire third_timer_clock_out_en = timer_three_mode[`TTU_T3M_OE];
  wire down_count_enable = timer_three_mode[`TTU_T3M_DOWN_COUNT_ENABLE];
  wire first_timer_run = classic_control[`TTU_CLC_RUN1];
  wire second_timer_run = classic_control[`TTU_CLC_RUN2];
  wire [1:0] first_mode = classic_mode[`TTU_CLM_MODE1_LSB+1:
    `TTU_CLM_MODE1_LSB];
  wire [1:0] second_mode = classic_mode[`TTU_CLM_MODE2_LSB+1:
    `TTU_CLM_MODE2_LSB];
  assign pointer_select = aux_control[`TTU_AUX_PTR_SEL];
  assign baud_adjust_bit = aux_control[`TTU_AUX_BAUD_ADJ];
  assign serial_mode0_speed_sel = aux_control_two[`TTU_AUX2_SER0];
  // Synchronised pins
  wire trig_level;
  wire trig_fall;
  wire count_fall;
  wire p1_fall;
  wire p2_fall;
  ttu_edge_sync u_trig (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .pin(trigger_pin), .level(trig_level), .fall(trig_fall));
  ttu_edge_sync u_count (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .pin(external_count_pin), .level(), .fall(count_fall));
  ttu_edge_sync u_p1 (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .pin(first_count_pin), .level(), .fall(p1_fall));
  ttu_edge_sync u_p2 (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .pin(second_count_pin), .level(), .fall(p2_fall));
  // Clock/12 and clock/2 time bases, one-cycle ticks
  wire tick12 = ce & (prescale == (`TTU_PRESCALE - 1));
  always @(posedge sys_clk) begin
    if (!rstn) begin
      prescale <= {`TTU_PRESCALE_W{1'b0}};
      half_tick <= 1'b0;
    end else if (ce) begin
      prescale <= tick12 ? {`TTU_PRESCALE_W{1'b0}} :
        prescale + {{(`TTU_PRESCALE_W-1){1'b0}}, 1'b1};
      half_tick <= ~half_tick;
    end
  end
  // Classic timer count sources
  wire base1 = first_timer_fast_clock_sel ? ce : tick12;
  wire base2 = second_timer_fast_clock_sel ? ce : tick12;
  wire src1 = classic_mode[`TTU_CLM_CT1] ? p1_fall : base1;
  wire src2 = classic_mode[`TTU_CLM_CT2] ? p2_fall : base2;
  wire step1 = first_timer_run & src1;
  wire step2 = second_timer_run & src2;
  wire split1 = (first_mode == `TTU_MODE_SPLIT);
  wire [7:0] t1_lo;
  wire [7:0] t1_hi;
  wire [7:0] t2_lo;
  wire [7:0] t2_hi;
  wire ovf1;
  wire ovf1_hi;
  wire ovf2;
  // First timer; its split high half borrows the second run bit
  ttu_classic_timer #(.SPLIT(1)) u_first (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .step(step1),
    .hi_step(second_timer_run & base2), .mode(first_mode),
    .wr_lo(wr_t1_lo), .wr_hi(wr_t1_hi), .wdata(sfr_wdata),
    .cnt_lo(t1_lo), .cnt_hi(t1_hi), .ovf(ovf1), .hi_ovf(ovf1_hi)
  );
  // Second timer holds in split mode
  ttu_classic_timer #(.SPLIT(0)) u_second (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .step(step2),
    .hi_step(1'b0), .mode(second_mode),
    .wr_lo(wr_t2_lo), .wr_hi(wr_t2_hi), .wdata(sfr_wdata),
    .cnt_lo(t2_lo), .cnt_hi(t2_hi), .ovf(ovf2), .hi_ovf()
  );
  // Third timer mode decode
  wire baud_mode = receive_clock_selector | transmit_clock_selector;
  wire clkout_mode = third_timer_clock_out_en & ~baud_mode &
    ~capture_reload_select;
  wire capture_mode = capture_reload_select & ~baud_mode;
  wire updown_mode = down_count_enable & ~baud_mode &
    ~capture_reload_select;
  wire fast_base = baud_mode | clkout_mode;
  wire [15:0] count16 = {t3_hi, t3_lo};
  wire [15:0] reload16 = {capture_reload_high, capture_reload_low};
  // Count source; baud and clock-out modes run on clock/2
  wire base3 = fast_base ? (ce & half_tick) :
    (third_timer_fast_clock_sel ? ce : tick12);
  wire src3 = timer_counter_select ? count_fall : base3;
  wire step3 = third_timer_run & src3;
  wire count_down = updown_mode & ~trig_level;
  wire up_ovf = step3 & ~count_down & (count16 == 16'hFFFF);
  wire down_ovf = step3 & count_down &
    (count16 == reload16);
  wire ovf3 = up_ovf | down_ovf;
  // Trigger edge effects; while clocking the serial port an edge only sets the external flag
  wire trig_evt = trig_fall & external_trigger_enable;
  wire capture_evt = trig_evt & capture_mode;
  wire reload_evt = trig_evt & ~baud_mode & ~capture_reload_select &
    ~down_count_enable;
  wire exf_set = capture_evt | reload_evt |
    (trig_evt & baud_mode);
  wire tf_set = ovf3 & ~baud_mode & ~clkout_mode;
  // Next count value; software writes take precedence
  always @* begin
    next_count = count16;
    if (down_ovf) begin
      next_count = 16'hFFFF;
    end else if (up_ovf) begin
      next_count = capture_mode ? 16'h0000 : reload16;
    end else if (reload_evt) begin
      next_count = reload16;
    end else if (step3) begin
      next_count = count_down ? count16 - 16'h0001 : count16 + 16'h0001;
    end
    if (wr_t3_lo) begin
      next_count[7:0] = sfr_wdata;
    end
    if (wr_t3_hi) begin
      next_count[15:8] = sfr_wdata;
    end
  end
  // External flag: written, toggled in up/down mode, set wins
  always @* begin
    next_exf = wr_t3c ? sfr_wdata[`TTU_T3C_EXF] : external_trigger_flag;
    if (ovf3 & updown_mode) begin
      next_exf = ~next_exf;
    end
    if (exf_set) begin
      next_exf = 1'b1;
    end
  end
  // Third timer registers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      capture_reload_select <= 1'b0;
      timer_counter_select <= 1'b0;
      third_timer_run <= 1'b0;
      external_trigger_enable <= 1'b0;
      transmit_clock_selector <= 1'b0;
      receive_clock_selector <= 1'b0;
      external_trigger_flag <= 1'b0;
      third_timer_overflow_flag <= 1'b0;
      capture_reload_low <= `TTU_RESET_BYTE;
      capture_reload_high <= `TTU_RESET_BYTE;
      t3_lo <= `TTU_RESET_BYTE;
      t3_hi <= `TTU_RESET_BYTE;
    end else if (ce) begin
      if (wr_t3c) begin
        capture_reload_select <= sfr_wdata[`TTU_T3C_CPRL];
        timer_counter_select <= sfr_wdata[`TTU_T3C_CT];
        third_timer_run <= sfr_wdata[`TTU_T3C_RUN];
        external_trigger_enable <= sfr_wdata[`TTU_T3C_EXEN];
        transmit_clock_selector <= sfr_wdata[`TTU_T3C_TRANSMIT_CLOCK_SELECTOR];
        receive_clock_selector <= sfr_wdata[`TTU_T3C_RCLK];
      end
      // Hardware never clears the overflow flag, but toggles the external flag in up/down mode; a set beats a clear
      third_timer_overflow_flag <= tf_set |
        (wr_t3c ? sfr_wdata[`TTU_T3C_TF] :
        third_timer_overflow_flag);
      external_trigger_flag <= next_exf;
      if (capture_evt) begin
        capture_reload_low <= t3_lo;
        capture_reload_high <= t3_hi;
      end else begin
        if (wr_cap_lo) begin
          capture_reload_low <= sfr_wdata;
        end
        if (wr_cap_hi) begin
          capture_reload_high <= sfr_wdata;
        end
      end
      t3_lo <= next_count[7:0];
      t3_hi <= next_count[15:8];
    end
  end
  // Control registers; reserved bits are never stored
  always @(posedge sys_clk) begin
    if (!rstn) begin
      aux_control <= `TTU_RESET_BYTE;
      aux_control_two <= `TTU_RESET_BYTE;
      timer_three_mode <= `TTU_RESET_BYTE;
      classic_control <= `TTU_RESET_BYTE;
      classic_mode <= `TTU_RESET_BYTE;
    end else if (ce) begin
      if (wr_aux) begin
        aux_control <= sfr_wdata & `TTU_AUX_MASK;
      end
      if (wr_aux2) begin
        aux_control_two <= sfr_wdata & `TTU_AUX2_MASK;
      end
      if (wr_t3m) begin
        timer_three_mode <= sfr_wdata & `TTU_T3M_MASK;
      end
      if (wr_clm) begin
        classic_mode <= sfr_wdata & `TTU_CLM_MASK;
      end
      if (wr_clc) begin
        classic_control[`TTU_CLC_RUN1] <= sfr_wdata[`TTU_CLC_RUN1];
        classic_control[`TTU_CLC_RUN2] <= sfr_wdata[`TTU_CLC_RUN2];
      end
      // Overflow flags: set beats a same-cycle software clear
      classic_control[`TTU_CLC_TF1] <= ovf1 |
        (wr_clc ? sfr_wdata[`TTU_CLC_TF1] : classic_control[`TTU_CLC_TF1]);
      classic_control[`TTU_CLC_TF2] <= (split1 ? ovf1_hi : ovf2) |
        (wr_clc ? sfr_wdata[`TTU_CLC_TF2] : classic_control[`TTU_CLC_TF2]);
    end
  end
  // Clock outputs toggle per overflow for a 50% duty; the first only in auto-reload 8-bit mode
  always @(posedge sys_clk) begin
    if (!rstn) begin
      first_clock_out <= 1'b0;
      third_clock_out <= 1'b0;
    end else if (ce) begin
      if (ovf1 & first_timer_clock_out_en & first_timer_run &
          (first_mode == `TTU_MODE_AUTO8)) begin
        first_clock_out <= ~first_clock_out;
      end
      if (ovf3 & third_timer_clock_out_en) begin
        third_clock_out <= ~third_clock_out;
      end
    end
  end
  assign first_clock_out_oe = first_timer_clock_out_en;
  assign third_clock_out_oe = third_timer_clock_out_en;
  // Serial clocks: selector picks third or second timer overflow
  assign rx_baud_tick = receive_clock_selector ? ovf3 : ovf2;
  assign tx_baud_tick = transmit_clock_selector ? ovf3 :
    ovf2;
  // Interrupt requests; the external flag is masked in up/down use
  assign third_timer_irq = third_timer_overflow_flag |
    (external_trigger_flag & ~down_count_enable);
  assign first_timer_irq = classic_control[`TTU_CLC_TF1];
  assign second_timer_irq = classic_control[`TTU_CLC_TF2];
  // Registered read port; unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      case (sfr_addr)
        `TTU_ADDR_AUX: sfr_rdata <= aux_control;
        `TTU_ADDR_AUX2: sfr_rdata <= aux_control_two;
        `TTU_ADDR_T3CTL: sfr_rdata <= {third_timer_overflow_flag,
          external_trigger_flag, receive_clock_selector,
          transmit_clock_selector, external_trigger_enable,
          third_timer_run, timer_counter_select, capture_reload_select};
        `TTU_ADDR_T3MOD: sfr_rdata <= timer_three_mode;
        `TTU_ADDR_CAP_LO: sfr_rdata <= capture_reload_low;
        `TTU_ADDR_CAP_HI: sfr_rdata <= capture_reload_high;
        `TTU_ADDR_T3_LO: sfr_rdata <= t3_lo;
        `TTU_ADDR_T3_HI: sfr_rdata <= t3_hi;
        `TTU_ADDR_CLCTL: sfr_rdata <= classic_control;
        `TTU_ADDR_CLMODE: sfr_rdata <= classic_mode;
        `TTU_ADDR_T1_LO: sfr_rdata <= t1_lo;
        `TTU_ADDR_T1_HI: sfr_rdata <= t1_hi;
        `TTU_ADDR_T2_LO: sfr_rdata <= t2_lo;
        `TTU_ADDR_T2_HI: sfr_rdata <= t2_hi;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule // ttu_top

// File: verif/tb.sv
// Self-checking bench for the three-timer unit
`timescale 1ns/100ps
`include "ttu_defs.vh"
module tb;
  reg sys_clk, rstn, sfr_wr, sfr_rd, trig_req, cnt_req;
  reg [7:0] sfr_addr, sfr_wdata, got;
  wire [7:0] sfr_rdata;
  wire trigger_pin, external_count_pin, rx_tick, tx_tick, t3_irq;
  wire f_out, f_irq, t3_out;
  integer failures, cmp_count, n_rx, n_tx, n_tg;
  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Enable and classic count pins tied; classic timers use the timebase
  ttu_top DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .trigger_pin(trigger_pin), .external_count_pin(external_count_pin),
    .first_count_pin(1'b1), .second_count_pin(1'b1),
    .first_clock_out(f_out), .first_clock_out_oe(), .third_clock_out(t3_out),
    .third_clock_out_oe(), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .pointer_select(), .baud_adjust_bit(), .serial_mode0_speed_sel(),
    .first_timer_irq(f_irq), .second_timer_irq(), .third_timer_irq(t3_irq));
  ttu_pin_model u_pins (.sys_clk(sys_clk), .trig_req(trig_req),
    .cnt_req(cnt_req), .trigger_pin(trigger_pin),
    .external_count_pin(external_count_pin));
  task stop_test;
    begin
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp, input string what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input string what);
    begin
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      @(negedge sys_clk);
      got = sfr_rdata;
      chk(got, e, what);
    end
  endtask
  // One falling edge on the trigger (0) or count (1) pin, then settle
  task fire(input sel);
    begin
      @(posedge sys_clk);
      if (sel) cnt_req <= 1'b1;
      else trig_req <= 1'b1;
      @(posedge sys_clk);
      cnt_req <= 1'b0;
      trig_req <= 1'b0;
      repeat (12) @(posedge sys_clk);
    end
  endtask
  task t_regs;
    begin
      rd(`TTU_ADDR_AUX, 8'h00, "aux");
      rd(`TTU_ADDR_T3CTL, 8'h00, "ctl");
      rd(`TTU_ADDR_T3MOD, 8'h00, "mod");
      wr(`TTU_ADDR_T3MOD, 8'hFF);
      rd(`TTU_ADDR_T3MOD, 8'h03, "mod_mask");
      rd(8'h00, 8'h00, "unmapped");
      wr(`TTU_ADDR_T3MOD, 8'h00);
    end
  endtask
  task t_capture;
    begin
      wr(`TTU_ADDR_T3_LO, 8'h34);
      wr(`TTU_ADDR_T3_HI, 8'h12);
      wr(`TTU_ADDR_T3CTL, 8'h01);
      fire(1'b0);
      rd(`TTU_ADDR_T3CTL, 8'h01, "ignored");
      wr(`TTU_ADDR_T3CTL, 8'h09);
      fire(1'b0);
      rd(`TTU_ADDR_CAP_LO, 8'h34, "cap_lo");
      rd(`TTU_ADDR_CAP_HI, 8'h12, "cap_hi");
      rd(`TTU_ADDR_T3CTL, 8'h49, "ext_flag");
      chk({7'h00, t3_irq}, 8'h01, "irq_ext");
      rd(`TTU_ADDR_T3_LO, 8'h34, "stopped");
      wr(`TTU_ADDR_T3MOD, 8'h01);
      @(negedge sys_clk);
      chk({7'h00, t3_irq}, 8'h00, "irq_masked");
      wr(`TTU_ADDR_T3MOD, 8'h00);
      wr(`TTU_ADDR_T3CTL, 8'h00);
    end
  endtask
  task t_counter;
    begin
      wr(`TTU_ADDR_T3CTL, 8'h06);
      repeat (3) fire(1'b1);
      wr(`TTU_ADDR_T3CTL, 8'h00);
      rd(`TTU_ADDR_T3_LO, 8'h37, "events");
    end
  endtask
  task t_wrap;
    begin
      wr(`TTU_ADDR_AUX, 8'h08);
      wr(`TTU_ADDR_T3_LO, 8'hFE);
      wr(`TTU_ADDR_T3_HI, 8'hFF);
      wr(`TTU_ADDR_T3CTL, 8'h05);
      repeat (4) @(posedge sys_clk);
      rd(`TTU_ADDR_T3CTL, 8'h85, "ovf_flag");
      wr(`TTU_ADDR_T3CTL, 8'h81);
      rd(`TTU_ADDR_T3_HI, 8'h00, "wrap");
      chk({7'h00, t3_irq}, 8'h01, "irq_ovf");
      wr(`TTU_ADDR_T3CTL, 8'h00);
    end
  endtask
  task t_slow;
    begin
      wr(`TTU_ADDR_AUX, 8'h00);
      wr(`TTU_ADDR_T3_LO, 8'h00);
      wr(`TTU_ADDR_T3_HI, 8'h00);
      wr(`TTU_ADDR_T3CTL, 8'h05);
      // With both write edges: 120 cycles, exactly ten clock/12 ticks
      repeat (118) @(posedge sys_clk);
      wr(`TTU_ADDR_T3CTL, 8'h01);
      rd(`TTU_ADDR_T3_LO, 8'h0A, "slow");
    end
  endtask
  task t_baud;
    begin
      wr(`TTU_ADDR_CAP_LO, 8'hFE);
      wr(`TTU_ADDR_CAP_HI, 8'hFF);
      // Start just below overflow, else the first tick is far away
      wr(`TTU_ADDR_T3_LO, 8'hFE);
      wr(`TTU_ADDR_T3_HI, 8'hFF);
      wr(`TTU_ADDR_T3CTL, 8'h34);
      n_rx = 0;
      n_tx = 0;
      repeat (40) begin
        @(negedge sys_clk);
        n_rx = n_rx + rx_tick;
        n_tx = n_tx + tx_tick;
      end
      chk({7'h00, n_rx >= 9 && n_rx <= 11}, 8'h01, "rx_rate");
      chk(n_tx[7:0], n_rx[7:0], "tx_rate");
      rd(`TTU_ADDR_T3CTL, 8'h34, "no_flag");
      wr(`TTU_ADDR_T3CTL, 8'h00);
    end
  endtask
  // Toggles on the first (0) or third (1) clock output over n cycles
  task count_out(input integer n, input sel);
    reg last;
    begin
      @(negedge sys_clk);
      last = sel ? t3_out : f_out;
      n_tg = 0;
      repeat (n) begin
        @(negedge sys_clk);
        n_tg = n_tg + ((sel ? t3_out : f_out) !== last);
        last = sel ? t3_out : f_out;
      end
    end
  endtask
  task t_first;
    begin
      wr(`TTU_ADDR_AUX2, 8'h81);
      wr(`TTU_ADDR_CLMODE, 8'h02);
      wr(`TTU_ADDR_T1_HI, 8'hFE);
      wr(`TTU_ADDR_T1_LO, 8'hFE);
      wr(`TTU_ADDR_CLCTL, 8'h01);
      // Reload FE, step every cycle: an overflow every two cycles
      count_out(40, 1'b0);
      chk(n_tg[7:0], 8'h14, "t1_fast_out");
      chk({7'h00, f_irq}, 8'h01, "t1_flag");
      wr(`TTU_ADDR_AUX2, 8'h01);
      // Clock/12: one overflow per 24 cycles
      count_out(48, 1'b0);
      chk(n_tg[7:0], 8'h02, "t1_slow_out");
      wr(`TTU_ADDR_CLCTL, 8'h00);
      wr(`TTU_ADDR_AUX2, 8'h00);
    end
  endtask
  task t_clkout;
    begin
      wr(`TTU_ADDR_T3_LO, 8'hFE);
      wr(`TTU_ADDR_T3_HI, 8'hFF);
      wr(`TTU_ADDR_T3MOD, 8'h02);
      wr(`TTU_ADDR_T3CTL, 8'h04);
      // Clock/2 steps, reload FFFE: an overflow every four cycles
      count_out(40, 1'b1);
      chk(n_tg[7:0], 8'h0A, "t3_clk_out");
      rd(`TTU_ADDR_T3CTL, 8'h04, "clkout_no_flag");
      wr(`TTU_ADDR_T3CTL, 8'h00);
      wr(`TTU_ADDR_T3MOD, 8'h00);
    end
  endtask
  initial begin
    failures = 0;
    cmp_count = 0;
    {rstn, sfr_wr, sfr_rd, trig_req, cnt_req} = 5'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs;
    t_capture;
    t_counter;
    t_wrap;
    t_slow;
    t_baud;
    t_clkout;
    t_first;
    stop_test;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures = failures + 1;
    stop_test;
  end
endmodule // tb

// File: verif/ttu_pin_model.sv
// Pin model: external trigger and event-count lines
`timescale 1ns/100ps
module ttu_pin_model (
  // Clock
  input wire sys_clk,
  // Requests from the bench
  input wire trig_req,
  input wire cnt_req,
  // Pins, idle high
  output wire trigger_pin,
  output wire external_count_pin
);
  reg [2:0] trig_low = 3'h0;
  reg [2:0] cnt_low = 3'h0;
  // Six low cycles, so the two-stage synchroniser always sees the edge
  always @(posedge sys_clk) begin
    trig_low <= trig_req ? 3'h6 : trig_low - {2'h0, trig_low != 3'h0};
    cnt_low <= cnt_req ? 3'h6 : cnt_low - {2'h0, cnt_low != 3'h0};
  end
  assign trigger_pin = (trig_low == 3'h0);
  assign external_count_pin = (cnt_low == 3'h0);
endmodule // ttu_pin_model

// File: verif/ttu_top_sva.sv
// Checker for the three-timer unit, bound to its top module
`timescale 1ns/100ps
`include "ttu_defs.vh"
module ttu_top_sva (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rstn,
  input wire ce,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // Outputs watched
  input wire third_clock_out,
  input wire third_clock_out_oe,
  input wire first_clock_out_oe,
  input wire rx_baud_tick,
  input wire third_timer_irq
);
  reg [1:0] mod_sh;
  reg rclk_sh;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the mode bits and receive selector, as software wrote them
  always @(posedge sys_clk) begin
    if (!rstn) begin
      mod_sh <= 2'h0;
      rclk_sh <= 1'b0;
    end else if (ce && sfr_wr && sfr_addr == `TTU_ADDR_T3MOD) begin
      mod_sh <= sfr_wdata[1:0];
    end else if (ce && sfr_wr && sfr_addr == `TTU_ADDR_T3CTL) begin
      rclk_sh <= sfr_wdata[5];
    end
  end
  sequence wr_mod;
    ce && sfr_wr && sfr_addr == `TTU_ADDR_T3MOD;
  endsequence
  sequence rd_mod;
    ce && sfr_rd && !sfr_wr && sfr_addr == `TTU_ADDR_T3MOD;
  endsequence
  oe_write_a: assert property (wr_mod |=>
    third_clock_out_oe == $past(sfr_wdata[1])) else $error("oe wrong");
  ckoe_write_a: assert property (
    ce && sfr_wr && sfr_addr == `TTU_ADDR_AUX2 |=>
    first_clock_out_oe == $past(sfr_wdata[0])) else $error("ckoe wrong");
  mode_read_a: assert property (rd_mod |=>
    sfr_rdata == {6'h00, $past(mod_sh)}) else $error("mode read wrong");
  unmap_read_a: assert property (ce && sfr_rd && sfr_addr == 8'h00 |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  irq_clear_a: assert property ($fell(third_timer_irq) |->
    $past(sfr_wr)) else $error("flag cleared by hardware");
  hold_out_a: assert property (!third_clock_out_oe [*2] |->
    $stable(third_clock_out)) else $error("clock out moved");
  baud_gap_a: assert property (rx_baud_tick && rclk_sh |=>
    !rx_baud_tick) else $error("baud ticks too close");
  rst_zero_a: assert property ($rose(rstn) |->
    !third_timer_irq && !third_clock_out_oe && !first_clock_out_oe)
    else $error("outputs not cleared by reset");
endmodule // ttu_top_sva
bind ttu_top ttu_top_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .third_clock_out(third_clock_out), .rx_baud_tick(rx_baud_tick),
  .third_clock_out_oe(third_clock_out_oe), .third_timer_irq(third_timer_irq),
  .first_clock_out_oe(first_clock_out_oe));
